// ==== core/mb_request_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module mb_request_checker #(
  parameter int MAX_BYTES = 256
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] own_addr_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_valid_in,
  input wire logic rx_start_in,
  input wire logic rx_end_in,
  input wire logic rx_line_err_in,
  input wire logic uif_session_in,
  input wire logic internal_processing_busy_flag_in,
  input wire logic nvm_alarm_in,
  input wire logic range_err_in,
  input wire logic cmd_disabled_in,
  output logic reg_rd_out,
  output logic [15:0] reg_addr_out,
  input wire logic [15:0] reg_data_in,
  output logic [7:0] tx_data_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  output logic tx_last_out,
  output logic [7:0] err_code_out,
  output logic err_log_out,
  output logic fwd_out
);
  // =====================================================
  // receive capture
  logic [8:0] len_q;
  logic [7:0] addr_q, fc_q, b2_q, b3_q, b4_q, b5_q, b6_q;
  logic bad_q;
  logic [7:0] last1_q, last2_q;

  // =====================================================
  // crc step over one byte
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ mb_check_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte


  // =====================================================
  // frame counting and running check
  // crc over all bytes except the trailing two
  logic [15:0] crc_lag_q;
  always_ff @(posedge core_clk_in) begin
    if (rst_in || rx_start_in) begin
      len_q <= '0;
      bad_q <= 1'b0;
      crc_lag_q <= mb_check_pkg::CRC_INIT;
      last1_q <= '0;
      last2_q <= '0;
    end else if (rx_valid_in) begin
      if (len_q == 9'(MAX_BYTES)) begin
        bad_q <= 1'b1;
      end else begin
        len_q <= len_q + 9'h001;
      end
      last1_q <= rx_data_in;
      last2_q <= last1_q;
      if (len_q >= 9'h002) begin
        crc_lag_q <= crc_byte(crc_lag_q, last2_q);
      end
      if (rx_line_err_in) begin
        bad_q <= 1'b1;
      end
    end else if (rx_line_err_in) begin
      bad_q <= 1'b1;
    end
  end


  // =====================================================
  // header field capture
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      {addr_q, fc_q, b2_q, b3_q, b4_q, b5_q, b6_q} <= '0;
    end else if (rx_valid_in) begin
      case (len_q)
        9'h000: addr_q <= rx_data_in;
        9'h001: fc_q <= rx_data_in;
        9'h002: b2_q <= rx_data_in;
        9'h003: b3_q <= rx_data_in;
        9'h004: b4_q <= rx_data_in;
        9'h005: b5_q <= rx_data_in;
        9'h006: b6_q <= rx_data_in;
        default: ;
      endcase
    end
  end

  // =====================================================
  // validation
  logic [15:0] start_w, cnt_w, crc_got_w;
  logic [16:0] sum_w;
  logic crc_ok_w, for_me_w;
  logic [7:0] cause_w, code_w;
  assign start_w = {b2_q, b3_q};
  assign cnt_w = {b4_q, b5_q};
  assign sum_w = {1'b0, start_w} + {1'b0, cnt_w};
  assign crc_got_w = {last1_q, last2_q};
  assign crc_ok_w = (len_q >= 9'h004) && (crc_got_w == crc_lag_q);
  assign for_me_w = (addr_q == own_addr_in) && (addr_q != mb_check_pkg::BCAST_ADDR);

  always_comb begin
    cause_w = 8'h00;
    code_w = 8'h00;
    // first failing check wins
    if (!(fc_q == mb_check_pkg::FC_READ || fc_q == mb_check_pkg::FC_WRITE1
        || fc_q == mb_check_pkg::FC_DIAG || fc_q == mb_check_pkg::FC_WRITEN)) begin
      cause_w = mb_check_pkg::EXC_FUNC;
      code_w = mb_check_pkg::ERR_FUNC_ADDR;
    end else if (fc_q == mb_check_pkg::FC_DIAG && start_w != mb_check_pkg::DIAG_SUB) begin
      cause_w = mb_check_pkg::EXC_FUNC;
      code_w = mb_check_pkg::ERR_FUNC_ADDR;
    end else if ((fc_q == mb_check_pkg::FC_WRITEN) ? (len_q < mb_check_pkg::LEN_MULTI_HDR
        || len_q != mb_check_pkg::LEN_MULTI_HDR + 9'(b6_q))
        : (len_q != mb_check_pkg::LEN_FIXED)) begin
      cause_w = mb_check_pkg::EXC_DATA;
      code_w = mb_check_pkg::ERR_DATA;
    end else if (start_w > mb_check_pkg::ADDR_TOP) begin
      cause_w = mb_check_pkg::EXC_ADDR;
      code_w = mb_check_pkg::ERR_FUNC_ADDR;
    end else if ((fc_q == mb_check_pkg::FC_READ || fc_q == mb_check_pkg::FC_WRITEN)
        && (cnt_w == 16'h0000 || cnt_w > mb_check_pkg::MAX_WR_CNT
        || (fc_q == mb_check_pkg::FC_READ && cnt_w > mb_check_pkg::MAX_RD_CNT))) begin
      cause_w = mb_check_pkg::EXC_DATA;
      code_w = mb_check_pkg::ERR_DATA;
    end else if ((fc_q == mb_check_pkg::FC_READ || fc_q == mb_check_pkg::FC_WRITEN)
        && sum_w >= mb_check_pkg::ADDR_LIMIT) begin
      cause_w = mb_check_pkg::EXC_ADDR;
      code_w = mb_check_pkg::ERR_FUNC_ADDR;
    end else if (fc_q == mb_check_pkg::FC_WRITEN && {8'h00, b6_q} != {cnt_w[14:0], 1'b0}) begin
      cause_w = mb_check_pkg::EXC_DATA;
      code_w = mb_check_pkg::ERR_DATA;
    end else if (uif_session_in) begin
      cause_w = mb_check_pkg::EXC_SLAVE;
      code_w = mb_check_pkg::ERR_UIF;
    end else if (internal_processing_busy_flag_in || nvm_alarm_in) begin
      cause_w = mb_check_pkg::EXC_SLAVE;
      code_w = mb_check_pkg::ERR_NVM;
    end else if (cmd_disabled_in) begin
      cause_w = mb_check_pkg::EXC_SLAVE;
      code_w = mb_check_pkg::ERR_CMD;
    end else if (fc_q != mb_check_pkg::FC_READ && range_err_in) begin
      cause_w = mb_check_pkg::EXC_SLAVE;
      code_w = mb_check_pkg::ERR_DATA;
    end
  end

  // =====================================================
  // transmit sequencer
  mb_check_pkg::tx_state_type st_q;
  logic [7:0] exc_q;
  logic [15:0] crc_tx_q, rd_addr_q, word_q;
  logic [4:0] left_q;
  logic [2:0] idx_q;
  logic hi_q;
  logic accept_w, take_w;
  assign accept_w = rx_end_in && !bad_q && !rx_line_err_in && crc_ok_w && for_me_w
      && st_q == mb_check_pkg::ST_IDLE;
  assign take_w = tx_valid_out && tx_ready_in;


  // =====================================================
  // error log and forward pulses
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      err_log_out <= 1'b0;
      err_code_out <= 8'h00;
      fwd_out <= 1'b0;
    end else begin
      err_log_out <= accept_w && cause_w != 8'h00;
      fwd_out <= accept_w && cause_w == 8'h00 && fc_q != mb_check_pkg::FC_READ;
      if (accept_w && cause_w != 8'h00) begin
        err_code_out <= code_w;
      end
    end
  end


  // =====================================================
  // reply byte stream
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_q <= mb_check_pkg::ST_IDLE;
      exc_q <= '0;
      crc_tx_q <= mb_check_pkg::CRC_INIT;
      rd_addr_q <= '0;
      word_q <= '0;
      left_q <= '0;
      idx_q <= '0;
      hi_q <= 1'b0;
      tx_data_out <= '0;
      tx_valid_out <= 1'b0;
      tx_last_out <= 1'b0;
    end else begin
      case (st_q)
        // wait for an accepted query
        mb_check_pkg::ST_IDLE: begin
          if (accept_w && (cause_w != 8'h00 || fc_q == mb_check_pkg::FC_READ)) begin
            exc_q <= cause_w;
            rd_addr_q <= start_w;
            left_q <= cnt_w[4:0];
            idx_q <= '0;
            crc_tx_q <= crc_byte(mb_check_pkg::CRC_INIT, addr_q);
            tx_data_out <= addr_q;
            tx_valid_out <= 1'b1;
            st_q <= mb_check_pkg::ST_HDR;
          end
        end
        // function code, then cause or byte count
        mb_check_pkg::ST_HDR: begin
          if (take_w) begin
            idx_q <= idx_q + 3'h1;
            if (idx_q == 3'h0) begin
              tx_data_out <= (exc_q != 8'h00) ? (fc_q + mb_check_pkg::FC_EXC_OFS) : fc_q;
              crc_tx_q <= crc_byte(crc_tx_q,
                  (exc_q != 8'h00) ? (fc_q + mb_check_pkg::FC_EXC_OFS) : fc_q);
            end else if (exc_q != 8'h00) begin
              tx_data_out <= exc_q;
              crc_tx_q <= crc_byte(crc_tx_q, exc_q);
              idx_q <= '0;
              st_q <= mb_check_pkg::ST_CRC;
            end else begin
              tx_data_out <= {2'b00, left_q, 1'b0};
              crc_tx_q <= crc_byte(crc_tx_q, {2'b00, left_q, 1'b0});
              st_q <= mb_check_pkg::ST_FETCH;
            end
          end
        end
        // next register or trailing check
        mb_check_pkg::ST_FETCH: begin
          if (take_w) begin
            tx_valid_out <= 1'b0;
          end
          if (!tx_valid_out || take_w) begin
            if (left_q == 5'h00) begin
              idx_q <= '0;
              tx_valid_out <= 1'b1;
              tx_data_out <= crc_tx_q[7:0];
              st_q <= mb_check_pkg::ST_CRC;
            end else begin
              tx_valid_out <= 1'b0;
              st_q <= mb_check_pkg::ST_DATA;
              hi_q <= 1'b1;
            end
          end
        end
        // register value, high then low
        mb_check_pkg::ST_DATA: begin
          if (hi_q && !tx_valid_out) begin
            word_q <= reg_data_in;
            tx_data_out <= reg_data_in[15:8];
            crc_tx_q <= crc_byte(crc_tx_q, reg_data_in[15:8]);
            tx_valid_out <= 1'b1;
          end else if (take_w && hi_q) begin
            hi_q <= 1'b0;
            tx_data_out <= word_q[7:0];
            crc_tx_q <= crc_byte(crc_tx_q, word_q[7:0]);
          end else if (take_w) begin
            rd_addr_q <= rd_addr_q + 16'h0001;
            left_q <= left_q - 5'h01;
            tx_valid_out <= 1'b0;
            st_q <= mb_check_pkg::ST_FETCH;
          end
        end
        // check value, low then high
        mb_check_pkg::ST_CRC: begin
          if (idx_q == 3'h0 && exc_q != 8'h00 && tx_data_out == exc_q && take_w) begin
            tx_data_out <= crc_tx_q[7:0];
            idx_q <= 3'h1;
          end else if (take_w && idx_q == 3'h0) begin
            tx_data_out <= crc_tx_q[15:8];
            tx_last_out <= 1'b1;
            idx_q <= 3'h2;
          end else if (take_w && idx_q == 3'h1) begin
            tx_data_out <= crc_tx_q[15:8];
            tx_last_out <= 1'b1;
            idx_q <= 3'h2;
          end else if (take_w) begin
            tx_valid_out <= 1'b0;
            tx_last_out <= 1'b0;
            st_q <= mb_check_pkg::ST_IDLE;
          end
        end
        default: st_q <= mb_check_pkg::ST_IDLE;
      endcase
    end
  end


  // =====================================================
  // register read port
  // register fetch strobe in the same cycle as data capture
  assign reg_rd_out = (st_q == mb_check_pkg::ST_DATA) && hi_q && !tx_valid_out;
  assign reg_addr_out = rd_addr_q;
endmodule : mb_request_checker
`default_nettype wire

// ==== core/mb_check_pkg.sv ====
package mb_check_pkg;
  // =====================================================
  // function codes
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE1 = 8'h06;
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [7:0] FC_WRITEN = 8'h10;
  localparam logic [7:0] FC_EXC_OFS = 8'h80;
  // =====================================================
  // exception causes and error log codes
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_DATA = 8'h03;
  localparam logic [7:0] EXC_SLAVE = 8'h04;
  localparam logic [7:0] ERR_FUNC_ADDR = 8'h88;
  localparam logic [7:0] ERR_UIF = 8'h89;
  localparam logic [7:0] ERR_NVM = 8'h8a;
  localparam logic [7:0] ERR_DATA = 8'h8c;
  localparam logic [7:0] ERR_CMD = 8'h8d;
  // =====================================================
  // limits
  localparam logic [15:0] ADDR_TOP = 16'h1fff;
  localparam logic [16:0] ADDR_LIMIT = 17'h02000;
  localparam logic [15:0] MAX_RD_CNT = 16'h0010;
  localparam logic [15:0] MAX_WR_CNT = 16'h0011;
  localparam logic [15:0] DIAG_SUB = 16'h0000;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam int MAX_LEN = 256;
  localparam logic [8:0] LEN_FIXED = 9'h008;
  localparam logic [8:0] LEN_MULTI_HDR = 9'h009;
  // =====================================================
  // transmit states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HDR = 3'b001,
    ST_FETCH = 3'b011,
    ST_DATA = 3'b010,
    ST_CRC = 3'b110
  } tx_state_type;
endpackage : mb_check_pkg

// ==== tb/mb_request_checker_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module mb_request_checker_mon (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] own_addr_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_valid_in,
  input wire logic rx_end_in,
  input wire logic reg_rd_out,
  input wire logic [15:0] reg_addr_out,
  input wire logic [7:0] tx_data_out,
  input wire logic tx_valid_out,
  input wire logic tx_ready_in,
  input wire logic tx_last_out,
  input wire logic [7:0] err_code_out,
  input wire logic err_log_out,
  input wire logic fwd_out
);
  // ========
  // query and reply tracking
  logic [8:0] ri_q;
  logic [7:0] ra_q, fc_q;
  logic [5:0] ti_q, rc_q;
  logic ex_q;
  logic [15:0] la_q;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  always_ff @(posedge core_clk_in) begin
    if (rst_in || rx_end_in) ri_q <= 9'h000;
    else if (rx_valid_in) ri_q <= ri_q + 9'h001;
    if (rx_valid_in && ri_q == 9'h000) ra_q <= rx_data_in;
    if (rx_valid_in && ri_q == 9'h001) fc_q <= rx_data_in;
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) ti_q <= 6'h00;
    else if (tx_valid_out && tx_ready_in) ti_q <= tx_last_out ? 6'h00 : ti_q + 6'h01;
    if (tx_valid_out && tx_ready_in && ti_q == 6'h01) ex_q <= tx_data_out[7];
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in || rx_end_in) rc_q <= 6'h00;
    else if (reg_rd_out) rc_q <= rc_q + 6'h01;
    if (reg_rd_out) la_q <= reg_addr_out;
  end
  sequence s_stall; tx_valid_out && !tx_ready_in; endsequence
  sequence s_cause; tx_valid_out && ti_q == 6'h02 && ex_q; endsequence
  hold_stall_a: assert property (s_stall |=> tx_valid_out && $stable(tx_data_out))
    else $error("reply byte changed while stalled");
  reply_start_a: assert property ($rose(tx_valid_out) && ti_q == 6'h00 |-> $past(rx_end_in))
    else $error("reply began without a query end");
  addr_echo_a: assert property (tx_valid_out && ti_q == 6'h00 |-> tx_data_out == own_addr_in)
    else $error("reply address wrong");
  exc_fc_a: assert property (tx_valid_out && ti_q == 6'h01 && fc_q != mb_check_pkg::FC_READ
    |-> tx_data_out == fc_q + mb_check_pkg::FC_EXC_OFS) else $error("exception function wrong");
  func_log_a: assert property (s_cause ##0 (tx_data_out <= 8'h02)
    |-> err_code_out == mb_check_pkg::ERR_FUNC_ADDR) else $error("log code for cause 1 or 2 wrong");
  data_log_a: assert property (s_cause ##0 (tx_data_out == 8'h03)
    |-> err_code_out == mb_check_pkg::ERR_DATA) else $error("log code for cause 3 wrong");
  last_byte_a: assert property (tx_valid_out && tx_last_out && ex_q |-> ti_q == 6'h04)
    else $error("exception reply length wrong");
  rd_order_a: assert property (reg_rd_out && rc_q != 6'h00 |-> reg_addr_out == la_q + 16'h0001)
    else $error("register reads not ascending");
  rd_limit_a: assert property (reg_rd_out |-> rc_q < 6'h10)
    else $error("more than sixteen register reads");
  silent_a: assert property (rx_end_in && (ra_q != own_addr_in || ra_q == 8'h00)
    |=> (!tx_valid_out && !err_log_out && !fwd_out) [*3]) else $error("answered foreign query");
endmodule : mb_request_checker_mon
bind mb_request_checker mb_request_checker_mon mon_inst (.core_clk_in, .rst_in, .own_addr_in,
  .rx_data_in, .rx_valid_in, .rx_end_in, .reg_rd_out, .reg_addr_out, .tx_data_out,
  .tx_valid_out, .tx_ready_in, .tx_last_out, .err_code_out, .err_log_out, .fwd_out);
`default_nettype wire

// ==== tb/mb_master_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module mb_master_model (
  input wire logic clk_in,
  input wire logic slow_in,
  output logic [7:0] data_out,
  output logic valid_out,
  output logic start_out,
  output logic end_out,
  output logic err_out,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  input wire logic tx_last_in,
  output logic tx_ready_out
);
  // ========
  // query sender and reply collector
  logic [7:0] got [$];
  logic done;
  logic [1:0] ph = 2'h0;
  initial {data_out, valid_out, start_out, end_out, err_out, done} = 13'h0000;
  assign tx_ready_out = !slow_in || ph == 2'h3;
  always @(posedge clk_in) begin
    ph <= ph + 2'h1;
    if (tx_valid_in && tx_ready_out) begin
      got.push_back(tx_data_in);
      if (tx_last_in) done <= 1'b1;
    end
  end
  function automatic logic [15:0] crc16(input logic [7:0] b [$]);
    logic [15:0] c;
    c = mb_check_pkg::CRC_INIT;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ mb_check_pkg::CRC_POLY : c >> 1;
    end
    return c;
  endfunction : crc16
  task automatic send(input logic [7:0] q [$], input int mode);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, mode == 1};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    got.delete();
    done = 1'b0;
    @(posedge clk_in);
    start_out <= 1'b1;
    foreach (q[i]) begin
      @(posedge clk_in);
      start_out <= 1'b0;
      data_out <= q[i];
      valid_out <= 1'b1;
      err_out <= mode == 2 && i == 2;
    end
    @(posedge clk_in);
    valid_out <= 1'b0;
    data_out <= ~data_out;
    err_out <= 1'b0;
    end_out <= 1'b1;
    @(posedge clk_in);
    end_out <= 1'b0;
  endtask : send
endmodule : mb_master_model
`default_nettype wire

// ==== tb/tb_modbus_rtu_slave_request_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_modbus_rtu_slave_request_checker;
  typedef struct packed {
    logic [3:0] n;
    logic [79:0] p;
    logic [4:0] f;
    logic [7:0] cause;
    logic [7:0] code;
  } row_type;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] own_addr_in = 8'h11;
  logic [4:0] fl = 5'h00;
  logic slow = 1'b0;
  logic [7:0] rx_data_in, tx_data_out, err_code_out;
  logic rx_valid_in, rx_start_in, rx_end_in, rx_line_err_in, reg_rd_out, tx_valid_out;
  logic tx_ready_in, tx_last_out, err_log_out, fwd_out, log_seen, fwd_seen;
  wire logic uif_session_in, internal_processing_busy_flag_in, nvm_alarm_in;
  wire logic range_err_in, cmd_disabled_in;
  logic [15:0] reg_addr_out, reg_data_in;
  logic [7:0] q [$], e [$];
  int bad_count = 0;
  int checks_done = 0;
  row_type rows [17] = '{
    '{4'h5, 80'h0500000001, 5'h00, 8'h01, 8'h88},
    '{4'h5, 80'h0800011234, 5'h00, 8'h01, 8'h88},
    '{4'h5, 80'h0320000001, 5'h00, 8'h02, 8'h88},
    '{4'h5, 80'h031ff00010, 5'h00, 8'h02, 8'h88},
    '{4'h5, 80'h0300000000, 5'h00, 8'h03, 8'h8c},
    '{4'h5, 80'h0300000011, 5'h00, 8'h03, 8'h8c},
    '{4'h4, 80'h03000001, 5'h00, 8'h03, 8'h8c},
    '{4'h9, 80'h100000000203aabbcc, 5'h00, 8'h03, 8'h8c},
    '{4'h5, 80'h0600100005, 5'h10, 8'h04, 8'h89},
    '{4'h5, 80'h0600100005, 5'h08, 8'h04, 8'h8a},
    '{4'h5, 80'h0600100005, 5'h04, 8'h04, 8'h8a},
    '{4'h5, 80'h0600100005, 5'h02, 8'h04, 8'h8c},
    '{4'h5, 80'h0600100005, 5'h01, 8'h04, 8'h8d},
    '{4'h5, 80'h0300000000, 5'h1f, 8'h03, 8'h8c},
    '{4'h5, 80'h0600100005, 5'h1f, 8'h04, 8'h89},
    '{4'h5, 80'h0800001234, 5'h00, 8'h00, 8'h00},
    '{4'h8, 80'h100000000102abcd, 5'h00, 8'h00, 8'h00}
  };
  assign {uif_session_in, internal_processing_busy_flag_in, nvm_alarm_in, range_err_in,
    cmd_disabled_in} = fl;
  assign reg_data_in = reg_rd_out ? ~reg_addr_out : reg_addr_out;
  mb_request_checker mb_request_checker_inst (.core_clk_in, .rst_in, .own_addr_in, .rx_data_in,
    .rx_valid_in, .rx_start_in, .rx_end_in, .rx_line_err_in, .uif_session_in,
    .internal_processing_busy_flag_in, .nvm_alarm_in, .range_err_in, .cmd_disabled_in,
    .reg_rd_out, .reg_addr_out, .reg_data_in, .tx_data_out, .tx_valid_out, .tx_ready_in,
    .tx_last_out, .err_code_out, .err_log_out, .fwd_out);
  mb_master_model mm (.clk_in(core_clk_in), .slow_in(slow), .data_out(rx_data_in),
    .valid_out(rx_valid_in), .start_out(rx_start_in), .end_out(rx_end_in),
    .err_out(rx_line_err_in), .tx_data_in(tx_data_out), .tx_valid_in(tx_valid_out),
    .tx_last_in(tx_last_out), .tx_ready_out(tx_ready_in));
  always #2.5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    if (err_log_out) log_seen <= 1'b1;
    if (fwd_out) fwd_seen <= 1'b1;
  end
  // ========
  // shared tasks
  task automatic run(input int mode);
    log_seen = 1'b0;
    fwd_seen = 1'b0;
    mm.send(q, mode);
    for (int k = 0; k < 400 && !mm.done; k++) @(posedge core_clk_in);
  endtask : run
  task automatic cmp_reply();
    logic [15:0] c;
    c = mm.crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    `CHK(mm.got.size(), e.size())
    foreach (e[j]) `CHK(mm.got[j], e[j])
  endtask : cmp_reply
  task conclude();
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    repeat (30000) @(posedge core_clk_in);
    bad_count++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(negedge core_clk_in);
    `CHK({tx_valid_out, err_log_out, fwd_out, err_code_out}, 11'h000)
    foreach (rows[i]) begin
      fl <= rows[i].f;
      q = {8'h11};
      for (int k = rows[i].n - 1; k >= 0; k--) q.push_back(rows[i].p[8 * k +: 8]);
      run(0);
      if (rows[i].cause == 8'h00) begin
        `CHK(fwd_seen, 1'b1)
        `CHK(mm.got.size(), 0)
      end else begin
        e = {8'h11, q[1] + 8'h80, rows[i].cause};
        cmp_reply();
        `CHK(err_code_out, rows[i].code)
        `CHK(log_seen, 1'b1)
      end
    end
    // sixteen registers at the top of the map, far side stalling
    slow <= 1'b1;
    q = {8'h11, 8'h03, 8'h1f, 8'hef, 8'h00, 8'h10};
    run(0);
    e = {8'h11, 8'h03, 8'h20};
    for (int a = 16'h1fef; a < 16'h2000 - 1; a++) begin
      e.push_back(~a[15:8]);
      e.push_back(~a[7:0]);
    end
    cmp_reply();
    slow <= 1'b0;
    // bad check value, line error, foreign and broadcast address, oversize
    for (int m = 1; m <= 5; m++) begin
      q = {m == 3 ? 8'h12 : m == 4 ? 8'h00 : 8'h11, 8'h06, 8'h00, 8'h10, 8'h00, 8'h05};
      if (m == 5) repeat (251) q.push_back(8'h00);
      run(m < 3 ? m : 0);
      `CHK({log_seen, fwd_seen}, 2'b00)
      `CHK(mm.got.size(), 0)
    end
    conclude();
  end
endmodule : tb_modbus_rtu_slave_request_checker
`default_nettype wire
